//--- inc/cmc_consts.vh
// constants for the clock multiplier control block: register offsets,
// field positions, reset values and timing counts.
// assumes a 40 MHz logic clock and 7-bit serial port addresses.
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

// register offsets on the serial port
`define CMC_ADDR_ENABLE_BAND  7'h12
`define CMC_ADDR_LOOP_FILTER  7'h14
`define CMC_ADDR_DIVIDERS     7'h15
`define CMC_ADDR_LOCK_STATE   7'h16
`define CMC_ADDR_BAND_READ    7'h17

// reset values
`define CMC_RST_ENABLE_BAND   8'h00
`define CMC_RST_LOOP_FILTER   8'he7
`define CMC_RST_DIVIDERS      8'hc9

// field positions, enable/band register
`define CMC_BIT_ENABLE        7
`define CMC_BIT_MANUAL        6
// field positions, dividers register
`define CMC_BIT_XPOINT        4
// field positions, status register
`define CMC_BIT_LOCK          7

// band limits and tuning level window around the midpoint
`define CMC_BAND_LOW          6'h00
`define CMC_BAND_HIGH         6'h3f
`define CMC_BAND_START        6'h20
`define CMC_TUNE_MID          4'h7
`define CMC_TUNE_WIN_LO       4'h6
`define CMC_TUNE_WIN_HI       4'h8

// band search settling time per step
`define CMC_CLK_MHZ           40
`define CMC_SETTLE_NS         10000
`define CMC_SETTLE_CYCLES     ((`CMC_SETTLE_NS * `CMC_CLK_MHZ + 999) / 1000)
`define CMC_SEARCH_STEPS      7'h40

// serial word length
`define CMC_SPI_BITS          5'h10
`define CMC_SPI_INSTR_BITS    5'h08

`endif

//--- logic/cmc_clock_multiplier_control.v
// clock multiplier control: registers, band search and status readback.
// assumes clk is the divided reference clock, and that lock and tuning
// level come from the analog loop asynchronously.
`timescale 1ns/10ps
`include "cmc_consts.vh"

module cmc_clock_multiplier_control #(
  parameter SETTLE_CYCLES = `CMC_SETTLE_CYCLES  // per band search step
) (
  input  wire       clk,
  input  wire       nrst,
  input  wire       spiClk,
  input  wire       spiCsN,
  input  wire       sdioIn,
  output wire       sdioOut,
  output wire       sdioOe,
  input  wire       lockDetect,
  input  wire [3:0] tuneLevelRaw,
  output reg        multiplierEnable,
  output reg  [5:0] bandSelect,
  output reg  [2:0] loopFilterBw,
  output reg  [4:0] pumpCurrentSet,
  output reg  [1:0] logicClockDiv,
  output reg  [4:0] logicDivRatio,
  output reg        crosspointEnable,
  output reg  [1:0] oscOutputDiv,
  output reg  [2:0] oscDivRatio,
  output reg  [1:0] feedbackDiv,
  output reg  [4:0] feedbackRatio,
  output reg        bandSearchBusy
);

  // band search states
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_SETTLE = 2'b01;
  localparam [1:0] ST_EVAL   = 2'b10;
  localparam [1:0] ST_DONE   = 2'b11;

  wire [6:0] regAddr;    // address of the current serial access
  wire [7:0] wrData;     // data of a completed write
  wire       wrStrobe;   // one-cycle write pulse
  reg  [7:0] rdWord;     // registered read data for the port

  reg  [7:0] enableBand; // enable, mode and manual band
  reg  [7:0] loopFilter; // bandwidth and pump current
  reg  [7:0] dividers;   // logic, crosspoint, oscillator, feedback

  reg        lockMeta;   // first stage, read only by lockSync
  reg        lockSync;
  reg  [3:0] tuneMeta;   // first stage, read only by tuneSync
  reg  [3:0] tuneSync;
  reg  [3:0] tunePrev;   // previous synchronised sample
  reg  [3:0] tuneHeld;   // level taken once two samples agree

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [5:0] autoBand;   // band chosen by the search
  reg  [5:0] next_autoBand;
  reg [15:0] settleCnt;  // cycles left to settle this step
  reg [15:0] next_settleCnt;
  reg  [6:0] stepCnt;    // steps taken, bounds a wandering search
  reg  [6:0] next_stepCnt;

  wire       enBit     = enableBand[`CMC_BIT_ENABLE];
  wire       manualBit = enableBand[`CMC_BIT_MANUAL];
  wire       autoRun   = enBit & ~manualBit;
  // a write to the dividers changes the loop, so search again
  wire       divWrite  = wrStrobe && regAddr == `CMC_ADDR_DIVIDERS;
  wire       lockFlag;
  wire [3:0] tuneLevel;
  wire [5:0] bandInUse;

  // serial port slave
  cmc_serial_port u_port (
    .clk      (clk),
    .nrst     (nrst),
    .spiClk   (spiClk),
    .spiCsN   (spiCsN),
    .sdioIn   (sdioIn),
    .sdioOut  (sdioOut),
    .sdioOe   (sdioOe),
    .regAddr  (regAddr),
    .wrData   (wrData),
    .wrStrobe (wrStrobe),
    .rdData   (rdWord)
  );

  // register writes; unmapped and read-only offsets are ignored
  always @(posedge clk) begin
    if (!nrst) begin
      enableBand <= `CMC_RST_ENABLE_BAND;
      loopFilter <= `CMC_RST_LOOP_FILTER;
      dividers   <= `CMC_RST_DIVIDERS;
    end else if (wrStrobe) begin
      case (regAddr)
        `CMC_ADDR_ENABLE_BAND: enableBand <= wrData;
        `CMC_ADDR_LOOP_FILTER: loopFilter <= wrData;
        // bit 5 is reserved and held at zero
        `CMC_ADDR_DIVIDERS:    dividers <= wrData & 8'hdf;
        default: ; // status offsets take no write
      endcase
    end
  end

  // lock and tuning level cross in through two flops each; the level is
  // a word, so a sample caught mid-change may skew between its bits and
  // is only taken once two synchronised samples in a row agree
  always @(posedge clk) begin
    if (!nrst) begin
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
      tuneMeta <= 4'h0;
      tuneSync <= 4'h0;
      tunePrev <= 4'h0;
      tuneHeld <= 4'h0;
    end else begin
      lockMeta <= lockDetect;
      lockSync <= lockMeta;
      tuneMeta <= tuneLevelRaw;
      tuneSync <= tuneMeta;
      tunePrev <= tuneSync;
      if (tuneSync == tunePrev)
        tuneHeld <= tuneSync;
    end
  end

  // lock is shown only once the loop is on and its band is settled
  assign lockFlag = lockSync & enBit &
                    (manualBit | state == ST_DONE);
  // level reads zero while the multiplier is off
  assign tuneLevel = enBit ? tuneHeld : 4'h0;
  // manual field only counts in manual mode
  assign bandInUse = manualBit ? enableBand[5:0] : autoBand;

  // band search: step towards the band that centres the tuning level
  always @* begin
    next_state     = state;
    next_autoBand  = autoBand;
    next_settleCnt = settleCnt;
    next_stepCnt   = stepCnt;
    case (state)
      ST_IDLE: begin
        if (autoRun) begin
          next_state     = ST_SETTLE;
          next_autoBand  = `CMC_BAND_START;
          next_settleCnt = SETTLE_CYCLES[15:0];
          next_stepCnt   = 7'h00;
        end
      end
      ST_SETTLE: begin
        // wait for the loop to follow the new band
        if (settleCnt <= 16'h0001)
          next_state = ST_EVAL;
        else
          next_settleCnt = settleCnt - 16'h0001;
      end
      ST_EVAL: begin
        next_settleCnt = SETTLE_CYCLES[15:0];
        next_stepCnt   = stepCnt + 7'h01;
        if (stepCnt >= `CMC_SEARCH_STEPS) begin
          // give up and keep the band tried last
          next_state = ST_DONE;
        end else if (tuneHeld > `CMC_TUNE_WIN_HI &&
                     autoBand != `CMC_BAND_HIGH) begin
          // level too high: a higher band pulls it down
          next_autoBand = autoBand + 6'h01;
          next_state    = ST_SETTLE;
        end else if (tuneHeld < `CMC_TUNE_WIN_LO &&
                     autoBand != `CMC_BAND_LOW) begin
          // level too low: a lower band raises it
          next_autoBand = autoBand - 6'h01;
          next_state    = ST_SETTLE;
        end else begin
          // centred around the midpoint, or at the end of the range
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (divWrite)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // leaving automatic mode or disabling drops the search
    if (!autoRun)
      next_state = ST_IDLE;
  end

  // band search registers
  always @(posedge clk) begin
    if (!nrst) begin
      state     <= ST_IDLE;
      autoBand  <= `CMC_BAND_START;
      settleCnt <= 16'h0000;
      stepCnt   <= 7'h00;
    end else begin
      state     <= next_state;
      autoBand  <= next_autoBand;
      settleCnt <= next_settleCnt;
      stepCnt   <= next_stepCnt;
    end
  end

  // control outputs come from flops; ratios decoded for the analog side
  always @(posedge clk) begin
    if (!nrst) begin
      multiplierEnable <= 1'b0;
      bandSelect       <= `CMC_BAND_START;
      loopFilterBw     <= 3'h0;
      pumpCurrentSet   <= 5'h00;
      logicClockDiv    <= 2'h0;
      logicDivRatio    <= 5'h02;
      crosspointEnable <= 1'b0;
      oscOutputDiv     <= 2'h0;
      oscDivRatio      <= 3'h1;
      feedbackDiv      <= 2'h0;
      feedbackRatio    <= 5'h02;
      bandSearchBusy   <= 1'b0;
    end else begin
      multiplierEnable <= enBit;
      bandSelect       <= bandInUse;
      loopFilterBw     <= loopFilter[7:5];
      pumpCurrentSet   <= loopFilter[4:0];
      logicClockDiv    <= dividers[7:6];
      crosspointEnable <= dividers[`CMC_BIT_XPOINT];
      oscOutputDiv     <= dividers[3:2];
      feedbackDiv      <= dividers[1:0];
      bandSearchBusy   <= autoRun & (state != ST_DONE);
      // logic clock ratio 2, 4, 8, 16; software keeps it under limit
      case (dividers[7:6])
        2'b00:   logicDivRatio <= 5'h02;
        2'b01:   logicDivRatio <= 5'h04;
        2'b10:   logicDivRatio <= 5'h08;
        default: logicDivRatio <= 5'h10;
      endcase
      // oscillator ratio: both upper codes mean four
      case (dividers[3:2])
        2'b00:   oscDivRatio <= 3'h1;
        2'b01:   oscDivRatio <= 3'h2;
        default: oscDivRatio <= 3'h4;
      endcase
      case (dividers[1:0])
        2'b00:   feedbackRatio <= 5'h02;
        2'b01:   feedbackRatio <= 5'h04;
        2'b10:   feedbackRatio <= 5'h08;
        default: feedbackRatio <= 5'h10;
      endcase
    end
  end

  // read data registered every cycle from the current address
  always @(posedge clk) begin
    if (!nrst) begin
      rdWord <= 8'h00;
    end else begin
      case (regAddr)
        `CMC_ADDR_ENABLE_BAND: rdWord <= enableBand;
        `CMC_ADDR_LOOP_FILTER: rdWord <= loopFilter;
        `CMC_ADDR_DIVIDERS:    rdWord <= dividers;
        `CMC_ADDR_LOCK_STATE:
          rdWord <= {lockFlag, 3'h0, tuneLevel};
        `CMC_ADDR_BAND_READ:   rdWord <= {2'h0, bandInUse};
        default:               rdWord <= 8'h00; // unmapped reads zero
      endcase
    end
  end

endmodule

//--- logic/cmc_serial_port.v
// three-wire serial port slave: one instruction byte, one data byte.
// assumes serial clock and select are slow against clk (at most clk/4)
// and arrive asynchronously; they are synchronised here.
`timescale 1ns/10ps
`include "cmc_consts.vh"

module cmc_serial_port (
  input  wire       clk,
  input  wire       nrst,
  input  wire       spiClk,
  input  wire       spiCsN,
  input  wire       sdioIn,
  output reg        sdioOut,
  output reg        sdioOe,
  output reg  [6:0] regAddr,
  output reg  [7:0] wrData,
  output reg        wrStrobe,
  input  wire [7:0] rdData
);

  reg        sclkMeta;   // first stage, read only by the second
  reg        sclkSync;
  reg        sclkLast;   // for edge detection
  reg        csMeta;
  reg        csSync;
  reg        sdioMeta;
  reg        sdioSync;
  reg [14:0] shiftIn;    // bits received so far
  reg [4:0]  bitCount;   // saturates at a full word
  reg        isRead;     // instruction asked for a read
  reg [7:0]  txShift;    // read data still to go out

  wire sclkRise = sclkSync & ~sclkLast & ~csSync;
  wire sclkFall = ~sclkSync & sclkLast & ~csSync;

  // two-flop synchronisers on all pins
  always @(posedge clk) begin
    if (!nrst) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      csMeta   <= 1'b1;
      csSync   <= 1'b1;
      sdioMeta <= 1'b0;
      sdioSync <= 1'b0;
    end else begin
      sclkMeta <= spiClk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      csMeta   <= spiCsN;
      csSync   <= csMeta;
      sdioMeta <= sdioIn;
      sdioSync <= sdioMeta;
    end
  end

  // shift in on rising edges, shift read data out on falling edges
  always @(posedge clk) begin
    if (!nrst) begin
      shiftIn  <= 15'h0000;
      bitCount <= 5'h00;
      isRead   <= 1'b0;
      regAddr  <= 7'h00;
      wrData   <= 8'h00;
      wrStrobe <= 1'b0;
      txShift  <= 8'h00;
      sdioOut  <= 1'b0;
      sdioOe   <= 1'b0;
    end else begin
      wrStrobe <= 1'b0;
      if (csSync) begin
        // deselected: frame ends, release the line
        bitCount <= 5'h00;
        sdioOe   <= 1'b0;
      end else if (sclkRise && bitCount < `CMC_SPI_BITS) begin
        shiftIn  <= {shiftIn[13:0], sdioSync};
        bitCount <= bitCount + 5'h01;
        if (bitCount == `CMC_SPI_INSTR_BITS - 5'h01) begin
          // instruction complete: read flag first, then address
          isRead  <= shiftIn[6];
          regAddr <= {shiftIn[5:0], sdioSync};
        end
        if (bitCount == `CMC_SPI_BITS - 5'h01 && !isRead) begin
          wrData   <= {shiftIn[6:0], sdioSync};
          wrStrobe <= 1'b1;
        end
      end else if (sclkFall && isRead) begin
        if (bitCount == `CMC_SPI_INSTR_BITS) begin
          // first data bit, rdData has long settled from regAddr
          sdioOut <= rdData[7];
          txShift <= {rdData[6:0], 1'b0};
          sdioOe  <= 1'b1;
        end else if (bitCount > `CMC_SPI_INSTR_BITS &&
                     bitCount < `CMC_SPI_BITS) begin
          sdioOut <= txShift[7];
          txShift <= {txShift[6:0], 1'b0};
        end
      end
    end
  end

endmodule

//--- tb/cmc_clock_multiplier_control_tb_top.sv
// testbench for the clock multiplier control block
// assumes a 40 MHz clk and serial frames at 5 MHz
`timescale 1ns/10ps
`include "cmc_consts.vh"

module cmc_clock_multiplier_control_tb_top;
  reg        clk, nrst, spiClk, spiCsN, sdioHost, lockDetect;
  reg  [3:0] tuneLevelRaw;
  wire       sdioOut, sdioOe, multiplierEnable, crosspointEnable;
  wire       bandSearchBusy;
  wire [5:0] bandSelect;
  wire [2:0] loopFilterBw, oscDivRatio;
  wire [4:0] pumpCurrentSet, logicDivRatio, feedbackRatio;
  wire [1:0] logicClockDiv, oscOutputDiv, feedbackDiv;
  integer    badCount, checksDone, cycles;
  // the shared data wire: block wins while it drives
  wire       sdioPin = sdioOe ? sdioOut : sdioHost;

  // short settle count keeps the band search quick
  cmc_clock_multiplier_control #(.SETTLE_CYCLES(4))
  i_cmc_clock_multiplier_control (
    .clk(clk), .nrst(nrst), .spiClk(spiClk), .spiCsN(spiCsN),
    .sdioIn(sdioPin), .sdioOut(sdioOut), .sdioOe(sdioOe),
    .lockDetect(lockDetect), .tuneLevelRaw(tuneLevelRaw),
    .multiplierEnable(multiplierEnable), .bandSelect(bandSelect),
    .loopFilterBw(loopFilterBw), .pumpCurrentSet(pumpCurrentSet),
    .logicClockDiv(logicClockDiv), .logicDivRatio(logicDivRatio),
    .crosspointEnable(crosspointEnable), .oscOutputDiv(oscOutputDiv),
    .oscDivRatio(oscDivRatio), .feedbackDiv(feedbackDiv),
    .feedbackRatio(feedbackRatio), .bandSearchBusy(bandSearchBusy));

  // 25 ns clock; it stands for the divided reference clock, under 75 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard: a whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles >= 20000) begin
      badCount = badCount + 1;
      stopTest;
    end
  end

  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task check(input string what, input [7:0] exp, input [7:0] got);
    checksDone = checksDone + 1;
    if (got !== exp) begin
      badCount = badCount + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one frame, msb first; read bits taken late in the high phase
  task xfer(input [15:0] word, output [7:0] got);
    integer i;
    @(posedge clk) spiCsN <= 1'b0;
    cyc(4);
    for (i = 15; i >= 0; i = i - 1) begin
      spiClk <= 1'b0;
      sdioHost <= word[i];
      cyc(4);
      spiClk <= 1'b1;
      cyc(4);
      if (i < 8) got[i] = sdioPin;
    end
    spiClk <= 1'b0;
    cyc(4);
    spiCsN <= 1'b1;
    sdioHost <= ~word[0];
    cyc(12);
  endtask

  task wr(input [6:0] a, input [7:0] d);
    reg [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask

  task rdChk(input string what, input [6:0] a, input [7:0] exp);
    reg [7:0] x;
    xfer({1'b1, a, 8'h00}, x);
    check(what, exp, x);
  endtask

  task t_reset;
    rdChk("enable_band", `CMC_ADDR_ENABLE_BAND, 8'h00);
    rdChk("loop_filter", `CMC_ADDR_LOOP_FILTER, 8'he7);
    rdChk("dividers", `CMC_ADDR_DIVIDERS, 8'hc9);
    rdChk("lock_state", `CMC_ADDR_LOCK_STATE, 8'h00);
    check("pump", 8'h07, {3'h0, pumpCurrentSet});
  endtask

  // every divider code, reserved bit 5 written high reads back low
  task t_dividers;
    integer c;
    reg [7:0] v;
    for (c = 0; c < 4; c = c + 1) begin
      v = {c[1:0], 1'b1, c[0], c[1:0], c[1:0]};
      wr(`CMC_ADDR_DIVIDERS, v);
      rdChk("div_read", `CMC_ADDR_DIVIDERS, v & 8'hdf);
      check("logic_ratio", 8'h02 << c, {3'h0, logicDivRatio});
      check("osc_ratio", (c > 1) ? 8'h04 : (8'h01 << c),
            {5'h0, oscDivRatio});
      check("fb_ratio", 8'h02 << c, {3'h0, feedbackRatio});
      check("xpoint", {7'h0, c[0]}, {7'h0, crosspointEnable});
    end
  endtask

  task t_loop;
    wr(`CMC_ADDR_LOOP_FILTER, 8'h5a);
    check("loop_bw", 8'h02, {5'h0, loopFilterBw});
    check("pump", 8'h1a, {3'h0, pumpCurrentSet});
  endtask

  // manual bands at both ends, status readback, refused writes
  task t_manual;
    lockDetect <= 1'b1;
    tuneLevelRaw <= 4'h3;
    wr(`CMC_ADDR_ENABLE_BAND, 8'hff);
    check("band", 8'h3f, {2'h0, bandSelect});
    check("enable", 8'h01, {7'h0, multiplierEnable});
    rdChk("lock_state", `CMC_ADDR_LOCK_STATE, 8'h83);
    rdChk("band_read", `CMC_ADDR_BAND_READ, 8'h3f);
    wr(`CMC_ADDR_ENABLE_BAND, 8'hc0);
    check("band", 8'h00, {2'h0, bandSelect});
    wr(`CMC_ADDR_LOCK_STATE, 8'h7c);
    rdChk("ro_write", `CMC_ADDR_LOCK_STATE, 8'h83);
    rdChk("unmapped", 7'h13, 8'h00);
    wr(`CMC_ADDR_ENABLE_BAND, 8'h40);
    check("enable", 8'h00, {7'h0, multiplierEnable});
    rdChk("tune_off", `CMC_ADDR_LOCK_STATE, 8'h00);
  endtask

  // disable first so each write starts a fresh search
  task search(input [3:0] lvl, input [7:0] val, input [7:0] exp);
    integer n;
    tuneLevelRaw <= lvl;
    wr(`CMC_ADDR_ENABLE_BAND, 8'h00);
    wr(`CMC_ADDR_ENABLE_BAND, val);
    n = 0;
    while (bandSearchBusy !== 1'b0 && n < 2000) begin
      n = n + 1;
      cyc(1);
    end
    check("search_busy", 8'h00, {7'h0, bandSearchBusy});
    check("search_band", exp, {2'h0, bandSelect});
  endtask

  task t_auto;
    search(4'hc, 8'h80, 8'h3f);
    rdChk("locked", `CMC_ADDR_LOCK_STATE, 8'h8c);
    search(4'h2, 8'h80, 8'h00);
    search(4'h7, 8'h85, 8'h20);
    rdChk("band_auto", `CMC_ADDR_BAND_READ, 8'h20);
    // a divider write while settled must start the search again
    tuneLevelRaw <= 4'hc;
    wr(`CMC_ADDR_DIVIDERS, `CMC_RST_DIVIDERS);
    cyc(300);
    check("div_research", 8'h3f, {2'h0, bandSelect});
  endtask

  task stopTest;
    $display("checks %0d errors %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // reset held 20 cycles, then the scenarios in turn
  initial begin
    badCount = 0;
    checksDone = 0;
    cycles = 0;
    nrst = 1'b0;
    spiClk = 1'b0;
    spiCsN = 1'b1;
    sdioHost = 1'b0;
    lockDetect = 1'b0;
    tuneLevelRaw = 4'h0;
    cyc(20);
    nrst <= 1'b1;
    cyc(4);
    t_reset;
    t_dividers;
    t_loop;
    t_manual;
    t_auto;
    stopTest;
  end
endmodule

//--- tb/cmc_monitor.sv
// checker for the clock multiplier control block, ports only
// assumes it is bound to cmc_clock_multiplier_control, one clock domain
`timescale 1ns/10ps

module cmc_monitor (
  input wire       clk,
  input wire       nrst,
  input wire       spiCsN,
  input wire       sdioOe,
  input wire       multiplierEnable,
  input wire [5:0] bandSelect,
  input wire [2:0] loopFilterBw,
  input wire [4:0] pumpCurrentSet,
  input wire [1:0] logicClockDiv,
  input wire [4:0] logicDivRatio,
  input wire       crosspointEnable,
  input wire [1:0] oscOutputDiv,
  input wire [2:0] oscDivRatio,
  input wire [1:0] feedbackDiv,
  input wire [4:0] feedbackRatio,
  input wire       bandSearchBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ratios are judged only once their code has settled; both are registered from dividers in the same cycle
  sequence s_logicHeld; $stable(logicClockDiv)[*2]; endsequence
  sequence s_oscHeld; $stable(oscOutputDiv)[*2]; endsequence
  sequence s_fbHeld; $stable(feedbackDiv)[*2]; endsequence
  // a search that has run a few cycles moves one band at a time
  sequence s_searching; bandSearchBusy[*3]; endsequence

  property p_logicRatio;
    s_logicHeld |-> logicDivRatio == (5'h02 << logicClockDiv);
  endproperty
  property p_oscRatio;
    s_oscHeld |-> oscDivRatio ==
      (oscOutputDiv[1] ? 3'h4 : (3'h1 << oscOutputDiv[0]));
  endproperty
  property p_fbRatio;
    s_fbHeld |-> feedbackRatio == (5'h02 << feedbackDiv);
  endproperty
  property p_resetVals;
    $rose(nrst) |-> ##[1:2] (loopFilterBw == 3'h7 && pumpCurrentSet == 5'h07
      && logicClockDiv == 2'h3 && oscOutputDiv == 2'h2 && feedbackDiv == 2'h1
      && !crosspointEnable && !multiplierEnable);
  endproperty
  property p_idleNoSearch;
    !multiplierEnable[*2] |-> !bandSearchBusy;
  endproperty
  property p_oeIdle;
    spiCsN[*6] |-> !sdioOe;
  endproperty
  property p_oeInFrame;
    $rose(sdioOe) |-> !spiCsN;
  endproperty
  property p_bandStep;
    s_searching |-> (bandSelect == $past(bandSelect)
      || bandSelect == $past(bandSelect) + 6'h01
      || bandSelect == $past(bandSelect) - 6'h01);
  endproperty

  a_logicRatio: assert property (p_logicRatio)
    else $error("logic clock ratio mismatch");
  a_oscRatio: assert property (p_oscRatio)
    else $error("oscillator ratio mismatch");
  a_fbRatio: assert property (p_fbRatio)
    else $error("feedback ratio mismatch");
  a_resetVals: assert property (p_resetVals)
    else $error("outputs after reset wrong");
  a_idleNoSearch: assert property (p_idleNoSearch)
    else $error("search busy while disabled");
  a_oeIdle: assert property (p_oeIdle)
    else $error("data driven outside a frame");
  a_oeInFrame: assert property (p_oeInFrame)
    else $error("data drive began without select");
  a_bandStep: assert property (p_bandStep)
    else $error("band search jumped");
endmodule

bind cmc_clock_multiplier_control cmc_monitor i_cmc_monitor (
  .clk(clk), .nrst(nrst), .spiCsN(spiCsN), .sdioOe(sdioOe),
  .multiplierEnable(multiplierEnable), .bandSelect(bandSelect),
  .loopFilterBw(loopFilterBw), .pumpCurrentSet(pumpCurrentSet),
  .logicClockDiv(logicClockDiv), .logicDivRatio(logicDivRatio),
  .crosspointEnable(crosspointEnable), .oscOutputDiv(oscOutputDiv),
  .oscDivRatio(oscDivRatio), .feedbackDiv(feedbackDiv),
  .feedbackRatio(feedbackRatio), .bandSearchBusy(bandSearchBusy));
